// ==== src/scm_cfg.svh ====
// Purpose: Constants for the per-channel management register bank
// Assumes: 16-bit registers, 5-bit register address
// Notes: Link timer figure is a default only; top exposes a parameter
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

`define SCM_ADDR_CTRL 5'h00
`define SCM_ADDR_STAT 5'h01

`define SCM_CTL_RESET 15
`define SCM_CTL_RSV14 14
`define SCM_CTL_SPD_LSB 13
`define SCM_CTL_AN_EN 12
`define SCM_CTL_RSV11 11
`define SCM_CTL_ISOLATE 10
`define SCM_CTL_AN_RESTART 9
`define SCM_CTL_DUPLEX 8
`define SCM_CTL_COL_TEST 7
`define SCM_CTL_SPD_MSB 6
`define SCM_CTL_UNIDIR 5

`define SCM_ST_EXT_STAT 8
`define SCM_ST_UNIDIR_ABL 7
`define SCM_ST_PRE_SUPP 6
`define SCM_ST_AN_DONE 5
`define SCM_ST_FAULT 4
`define SCM_ST_AN_ABL 3
`define SCM_ST_LINK 2

`define SCM_RST_AN_EN 1'b1
`define SCM_RST_ISOLATE 1'b1
`define SCM_RST_UNIDIR 1'b0
`define SCM_RST_RSV 1'b0

// Link timer of 10 ms at 8 ns per cycle
`define SCM_LINK_TIMER_NS 10000000
`define SCM_CLK_PERIOD_NS 8
`define SCM_LINK_TIMER_CYC (`SCM_LINK_TIMER_NS / `SCM_CLK_PERIOD_NS)

`endif

// ==== src/scm_pkg.sv ====
// Purpose: Types for the per-channel management register bank
// Assumes: Constants live in scm_cfg.svh
// Notes: None
package scm_pkg;
  typedef logic [15:0] scm_word_t;
  typedef logic [4:0] scm_addr_t;
  typedef enum logic [1:0] {
    SCM_SYNC_OK,
    SCM_SYNC_LOSING,
    SCM_SYNC_DOWN
  } scm_sync_t;
endpackage

// ==== src/scm_channel_regs.sv ====
// Purpose: Control and status registers of one channel (channels 1 to 3)
// Assumes: Management access is decoded upstream into rd/wr strobes with
//   a register address; link inputs arrive from another clock domain
// Notes: Unmapped addresses read zero, writes there are dropped
//
// Behaviour
// - Writing one to control bit 15 pulses channel reset; bit reads zero.
// - Control bits 14 and 11 store and read back writes, default zero.
// - Control bit 13 reads 0, bit 6 reads 1: fixed 1000 Mb/s.
// - Control bit 10 isolates channel from GMII side; defaults to one.
// - Control bit 8 reads one (full duplex), bit 7 reads zero.
// - Bit 5 with negotiation off enables transmit without link; default zero.
// - Control bits 4 to 0 read zero and ignore writes.
// - Status bits 15 to 9 read zero.
// - Status bit 8 reads one: extended status present.
// - Status bit 7 reads one; writes have no effect.
// - Status bit 6 reads one: preamble suppression accepted.
// - Status bit 5 shows negotiation complete; read only, reset zero.
// - Status bit 4 shows medium fault; clears when status is read.
// - Status bit 3 reads one: negotiation ability.
// - Status bit 2 latches zero on link loss until status read.
// - Status read reloads link bit with present link state.
// - Link bit one needs sync and, if enabled, completed negotiation.
// - Link drops for sync loss only after sync absent a whole link timer period.
// - Status bit 1 reads zero: no jabber detection.
// - Status bit 0 reads zero: no extended capability.
`timescale 1ns/1ps
`include "scm_cfg.svh"

module scm_channel_regs #(
  parameter int unsigned LINK_TIMER_CYC = `SCM_LINK_TIMER_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic link_sync_in,
  input wire logic an_done_in,
  input wire logic medium_fault_in,
  output logic chan_reset,
  output logic an_enable,
  output logic an_restart,
  output logic isolate,
  output logic unidir_tx,
  output logic tx_link_ok
);

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n = rst_sync_ff;

  // ==========================================================
  // Input synchronisers
  // Link side runs in another domain; first stage read only by the second
  logic [2:0] in_meta_ff;
  logic [2:0] in_sync_ff;
  wire [2:0] in_raw = {medium_fault_in, an_done_in, link_sync_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_meta_ff[gi] <= 1'b0;
          in_sync_ff[gi] <= 1'b0;
        end else begin
          in_meta_ff[gi] <= in_raw[gi];
          in_sync_ff[gi] <= in_meta_ff[gi];
        end
      end
    end
  endgenerate

  wire sync_now = in_sync_ff[0];
  wire an_done_now = in_sync_ff[1];
  wire fault_now = in_sync_ff[2];

  // ==========================================================
  // Access decode
  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] r);
    addr_hit = (a == r);
  endfunction

  wire wr_ctrl = mgmt_wr && addr_hit(mgmt_addr, `SCM_ADDR_CTRL);
  wire rd_stat = mgmt_rd && addr_hit(mgmt_addr, `SCM_ADDR_STAT);
  wire rd_ctrl = mgmt_rd && addr_hit(mgmt_addr, `SCM_ADDR_CTRL);

  // ==========================================================
  // Control register
  logic rsv14_ff;
  logic rsv11_ff;
  logic an_en_ff;
  logic isolate_ff;
  logic unidir_ff;
  logic chan_reset_ff;
  logic an_restart_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv14_ff <= `SCM_RST_RSV;
    end else if (wr_ctrl) begin
      rsv14_ff <= mgmt_wdata[`SCM_CTL_RSV14];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv11_ff <= `SCM_RST_RSV;
    end else if (wr_ctrl) begin
      rsv11_ff <= mgmt_wdata[`SCM_CTL_RSV11];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_en_ff <= `SCM_RST_AN_EN;
    end else if (wr_ctrl) begin
      an_en_ff <= mgmt_wdata[`SCM_CTL_AN_EN];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      isolate_ff <= `SCM_RST_ISOLATE;
    end else if (wr_ctrl) begin
      isolate_ff <= mgmt_wdata[`SCM_CTL_ISOLATE];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unidir_ff <= `SCM_RST_UNIDIR;
    end else if (wr_ctrl) begin
      unidir_ff <= mgmt_wdata[`SCM_CTL_UNIDIR];
    end
  end

  // Self-clearing strobes: one cycle each, never stored for readback
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reset_ff <= 1'b0;
    end else begin
      chan_reset_ff <= wr_ctrl && mgmt_wdata[`SCM_CTL_RESET];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_restart_ff <= 1'b0;
    end else begin
      an_restart_ff <= wr_ctrl && mgmt_wdata[`SCM_CTL_AN_RESTART];
    end
  end

  // ==========================================================
  // Link qualification
  // Sync loss must persist a whole link timer before link is dropped
  scm_pkg::scm_sync_t sync_st_ff;
  scm_pkg::scm_sync_t nxt_sync_st;
  logic [31:0] loss_cnt_ff;
  logic [31:0] nxt_loss_cnt;
  wire timer_done = (loss_cnt_ff >= LINK_TIMER_CYC - 32'h1);

  always_comb begin
    nxt_sync_st = sync_st_ff;
    nxt_loss_cnt = 32'h0;
    unique case (sync_st_ff)
      scm_pkg::SCM_SYNC_DOWN: begin
        if (sync_now) begin
          nxt_sync_st = scm_pkg::SCM_SYNC_OK;
        end
      end
      scm_pkg::SCM_SYNC_OK: begin
        if (!sync_now) begin
          nxt_sync_st = scm_pkg::SCM_SYNC_LOSING;
        end
      end
      scm_pkg::SCM_SYNC_LOSING: begin
        if (sync_now) begin
          nxt_sync_st = scm_pkg::SCM_SYNC_OK;
        end else if (timer_done) begin
          nxt_sync_st = scm_pkg::SCM_SYNC_DOWN;
        end else begin
          nxt_loss_cnt = loss_cnt_ff + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_st_ff <= scm_pkg::SCM_SYNC_DOWN;
      loss_cnt_ff <= 32'h0;
    end else begin
      sync_st_ff <= nxt_sync_st;
      loss_cnt_ff <= nxt_loss_cnt;
    end
  end

  wire sync_held = (sync_st_ff != scm_pkg::SCM_SYNC_DOWN);
  wire link_now = sync_held && (!an_en_ff || an_done_now);

  // ==========================================================
  // Status latches
  logic link_lat_ff;
  logic fault_lat_ff;
  logic an_done_ff;

  // Loss sticks low; a status read reloads present state, but a loss in
  // that same cycle still wins so no drop is hidden
  wire nxt_link_lat = !link_now ? 1'b0 : (rd_stat ? 1'b1 : link_lat_ff);
  // Fault is sticky high; a new fault wins over the read clear
  wire nxt_fault_lat = fault_now ? 1'b1 : (rd_stat ? 1'b0 : fault_lat_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_lat_ff <= 1'b0;
    end else begin
      link_lat_ff <= nxt_link_lat;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_lat_ff <= 1'b0;
    end else begin
      fault_lat_ff <= nxt_fault_lat;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_done_ff <= 1'b0;
    end else begin
      an_done_ff <= an_done_now;
    end
  end

  // ==========================================================
  // Read data
  // Fixed bits come from constants; status bits 15:9, 1, 0 are zero
  wire [15:0] ctrl_word = {
    1'b0,
    rsv14_ff,
    1'b0,
    an_en_ff,
    rsv11_ff,
    isolate_ff,
    1'b0,
    1'b1,
    1'b0,
    1'b1,
    unidir_ff,
    5'h00
  };

  wire [15:0] stat_word = {
    7'h00,
    1'b1,
    1'b1,
    1'b1,
    an_done_ff,
    fault_lat_ff,
    1'b1,
    link_lat_ff,
    1'b0,
    1'b0
  };

  wire [15:0] nxt_rdata = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 16'h0000);

  logic [15:0] rdata_ff;
  logic an_en_out_ff;
  logic isolate_out_ff;
  logic unidir_out_ff;
  logic tx_ok_ff;

  // Read data holds between reads so a slow station can sample late
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (mgmt_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_en_out_ff <= `SCM_RST_AN_EN;
    end else begin
      an_en_out_ff <= an_en_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      isolate_out_ff <= `SCM_RST_ISOLATE;
    end else begin
      isolate_out_ff <= isolate_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unidir_out_ff <= `SCM_RST_UNIDIR;
    end else begin
      unidir_out_ff <= unidir_ff && !an_en_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ok_ff <= 1'b0;
    end else begin
      tx_ok_ff <= link_now || (unidir_ff && !an_en_ff);
    end
  end

  assign mgmt_rdata = rdata_ff;
  assign chan_reset = chan_reset_ff;
  assign an_enable = an_en_out_ff;
  assign an_restart = an_restart_ff;
  assign isolate = isolate_out_ff;
  assign unidir_tx = unidir_out_ff;
  assign tx_link_ok = tx_ok_ff;

endmodule

// ==== dv/scm_channel_regs_checker.sv ====
// Purpose: Port assertions for scm_channel_regs
// Assumes: One clock, strobes one cycle wide
// Notes: Bound to every instance below
`timescale 1ns/1ps
module scm_channel_regs_checker #(
  parameter int unsigned LINK_TIMER_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic link_sync_in,
  input wire logic an_done_in,
  input wire logic medium_fault_in,
  input wire logic chan_reset,
  input wire logic an_enable,
  input wire logic an_restart,
  input wire logic isolate,
  input wire logic unidir_tx,
  input wire logic tx_link_ok
);
  // ====
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ctl_wr = mgmt_wr && mgmt_addr == 5'h00;
  a_reset_pulse: assert property (ctl_wr && mgmt_wdata[15] |=> chan_reset ##1 !chan_reset)
    else $error("channel reset pulse wrong");
  a_reset_cause: assert property (chan_reset |-> $past(ctl_wr) && $past(mgmt_wdata[15]))
    else $error("channel reset without write");
  a_restart_pulse: assert property (ctl_wr && mgmt_wdata[9] |=> an_restart ##1 !an_restart)
    else $error("restart pulse wrong");
  a_ctrl_fixed: assert property (mgmt_rd && mgmt_addr == 5'h00 |=> (mgmt_rdata & 16'hA3DF) == 16'h0140)
    else $error("control constant bits wrong");
  a_stat_fixed: assert property (mgmt_rd && mgmt_addr == 5'h01 |=> (mgmt_rdata & 16'hFFCB) == 16'h01C8)
    else $error("status constant bits wrong");
  a_unidir_gate: assert property (unidir_tx |-> !an_enable)
    else $error("unidirectional with negotiation on");
  a_unidir_link: assert property (unidir_tx |-> ##[0:1] tx_link_ok)
    else $error("unidirectional without transmit");
  // Channel reset pulses are excluded too, though they leave read data unchanged
  a_rdata_hold: assert property (!mgmt_rd && !chan_reset |=> $stable(mgmt_rdata))
    else $error("read data moved without read");
  c_reset: cover property (chan_reset);
  c_restart: cover property (an_restart);
  c_unidir: cover property (unidir_tx && tx_link_ok);
endmodule
bind scm_channel_regs scm_channel_regs_checker #(.LINK_TIMER_CYC(LINK_TIMER_CYC)) chk_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .link_sync_in(link_sync_in), .an_done_in(an_done_in), .medium_fault_in(medium_fault_in),
  .chan_reset(chan_reset), .an_enable(an_enable), .an_restart(an_restart),
  .isolate(isolate), .unidir_tx(unidir_tx), .tx_link_ok(tx_link_ok));

// ==== dv/scm_station.sv ====
// Purpose: Management station model driving register strobes
// Assumes: Strobes launched and released at rising edges
// Notes: Idle address and data show inverse of last value
`timescale 1ns/1ps
module scm_station (
  input wire logic ref_clk,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  // ====
  // Bus tasks
  initial begin
    mgmt_wr = 1'h0;
    mgmt_rd = 1'h0;
    mgmt_addr = 5'h1F;
    mgmt_wdata = 16'h0000;
  end
  task automatic wr(input scm_pkg::scm_addr_t a, input scm_pkg::scm_word_t d);
    @(posedge ref_clk);
    mgmt_wr <= 1'h1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge ref_clk);
    mgmt_wr <= 1'h0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask
  task automatic rd(input scm_pkg::scm_addr_t a, output scm_pkg::scm_word_t d);
    @(posedge ref_clk);
    mgmt_rd <= 1'h1;
    mgmt_addr <= a;
    @(posedge ref_clk);
    mgmt_rd <= 1'h0;
    mgmt_addr <= ~a;
    @(posedge ref_clk);
    d = mgmt_rdata;
  endtask
  // Second read shows live link, not a past loss
  task automatic confirm(output scm_pkg::scm_word_t d);
    rd(5'h01, d);
    rd(5'h01, d);
  endtask
endmodule

// ==== dv/scm_channel_regs_tb.sv ====
// Purpose: Self-checking bench for scm_channel_regs
// Assumes: Link timer shortened to 16 cycles
// Notes: Scenarios run in a fixed order, state carries over
`timescale 1ns/1ps
module scm_channel_regs_tb;
  logic ref_clk, rst_b, mgmt_wr, mgmt_rd, chan_reset, an_enable, an_restart;
  logic isolate, unidir_tx, tx_link_ok, link_sync_in, an_done_in, medium_fault_in;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  scm_pkg::scm_word_t d;
  int error_cnt = 0;
  int total_checks = 0;
  wire [15:0] outs = {12'h000, an_enable, isolate, unidir_tx, tx_link_ok};
  // ====
  // Instances
  scm_channel_regs #(.LINK_TIMER_CYC(16)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .link_sync_in(link_sync_in), .an_done_in(an_done_in),
    .medium_fault_in(medium_fault_in), .chan_reset(chan_reset), .an_enable(an_enable),
    .an_restart(an_restart), .isolate(isolate), .unidir_tx(unidir_tx),
    .tx_link_ok(tx_link_ok));
  scm_station st (.ref_clk(ref_clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
  // ====
  // Helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_defaults;
    chk("outs", 16'h000C, outs);
    st.rd(5'h00, d);
    chk("ctrl", 16'h1540, d);
    st.rd(5'h01, d);
    chk("stat", 16'h01C8, d);
  endtask
  task automatic t_refused;
    st.wr(5'h02, 16'hFFFF);
    st.rd(5'h02, d);
    chk("unmapped", 16'h0000, d);
    st.wr(5'h01, 16'h0000);
    st.rd(5'h01, d);
    chk("stat_wr", 16'h01C8, d);
  endtask
  task automatic t_ctrl;
    st.wr(5'h00, 16'h7FFF);
    st.rd(5'h00, d);
    chk("ctrl_ones", 16'h5D60, d);
    st.wr(5'h00, 16'h0020);
    st.rd(5'h00, d);
    chk("ctrl_uni", 16'h0160, d);
    chk("outs_uni", 16'h0003, outs);
    st.wr(5'h00, 16'h8200);
    #1;
    chk("pulses_on", 16'h0003, {14'h0000, chan_reset, an_restart});
    wait_c(1);
    #1;
    chk("pulses_off", 16'h0000, {14'h0000, chan_reset, an_restart});
    wait_c(3);
    st.rd(5'h00, d);
    chk("rst_bit", 16'h0000, d & 16'h8000);
  endtask
  task automatic t_link;
    st.wr(5'h00, 16'h0000);
    link_sync_in <= 1'h1;
    wait_c(6);
    st.confirm(d);
    chk("link_up", 16'h01CC, d);
    link_sync_in <= 1'h0;
    wait_c(8);
    link_sync_in <= 1'h1;
    wait_c(6);
    st.rd(5'h01, d);
    chk("short_loss", 16'h01CC, d);
    link_sync_in <= 1'h0;
    wait_c(40);
    link_sync_in <= 1'h1;
    wait_c(6);
    st.rd(5'h01, d);
    chk("latched", 16'h01C8, d);
    st.rd(5'h01, d);
    chk("reloaded", 16'h01CC, d);
  endtask
  task automatic t_an;
    st.wr(5'h00, 16'h1000);
    wait_c(6);
    st.confirm(d);
    chk("an_wait", 16'h01C8, d);
    an_done_in <= 1'h1;
    wait_c(6);
    st.confirm(d);
    chk("an_done", 16'h01EC, d);
    chk("outs_an", 16'h0009, outs);
  endtask
  task automatic t_fault;
    medium_fault_in <= 1'h1;
    wait_c(4);
    medium_fault_in <= 1'h0;
    wait_c(3);
    st.rd(5'h01, d);
    chk("fault", 16'h01FC, d);
    st.rd(5'h01, d);
    chk("fault_clr", 16'h01EC, d);
  endtask
  // ====
  // Run
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rst_b = 1'h0;
    link_sync_in = 1'h0;
    an_done_in = 1'h0;
    medium_fault_in = 1'h0;
    wait_c(10);
    rst_b <= 1'h1;
    wait_c(3);
    t_defaults();
    t_refused();
    t_ctrl();
    t_link();
    t_an();
    t_fault();
    wrap_up();
  end
  // Bound is about 29 times the expected run length of some 170 cycles
  initial begin
    wait_c(5000);
    error_cnt++;
    wrap_up();
  end
endmodule
